//--- rtl/blmd_top.sv
// two-channel twelve-point bar level meter with grid multiplexing, peak hold and mute
// oscillator: a divided tick of REF_CLK, one tick per OSC_DIV clocks
// frame: eight ticks; grid one owns slot 0, grid two owns slot 4
// segment loads: slot 7 for the first channel, slot 3 for the second
// loads land while both grids are dark, so no section glows a mixed pattern
// slot counter leaves reset at 1, so the first frame opens dark
// quantiser: one comparator chain per channel, thresholds falling with index
// bar height: count of thresholds met, 0 to 12, drawn as a thermometer
// input select steers both the level source and the threshold set
// peak hold: ac mode only, a held height and a tick timer per channel
// held height shown only from point 5 up; below that the present bar shows
// hold expiry: held height drops to the present height, timer restarts
// a mode change clears both holds, but a load in the very cycle of a switch to dc can still draw the ac peak
// power-on mute: tick counter, segments forced dark until it runs out
// forced mute: segments dark from the next clock; grids keep scanning
// all counts scale with OSC_DIV, so hold and mute follow the tick rate
// outputs come straight from flip-flops, one register stage after the decision
// limitation: a held peak is drawn as a full bar, not a lone point
// limitation: levels arrive as digital codes, dB for ac and millivolts for dc
// limitation: no front-end smoothing; the level codes are used as they come
// hazard: levels changing mid-frame may show different heights on the two grids
`timescale 1ns/100ps
`include "blmd_defs.svh"

module blmd_top #(
    parameter int OSC_DIV    = `BLMD_CLK_HZ / `BLMD_OSC_HZ,
    parameter int HOLD_TICKS = `BLMD_HOLD_MS * `BLMD_OSC_HZ / 1000,
    parameter int MUTE_TICKS = `BLMD_MUTE_MS * `BLMD_OSC_HZ / 1000
) (
    // clock and reset
    input  wire logic               REF_CLK,
    input  wire logic               RESET,
    // mode and mute controls
    input  wire logic               AC_SELECT,
    input  wire logic               MUTE,
    // ac levels in dB about point 8
    input  wire logic signed [12:0] FIRST_CHANNEL_AC_LEVEL,
    input  wire logic signed [12:0] SECOND_CHANNEL_AC_LEVEL,
    // dc levels in millivolts
    input  wire logic signed [12:0] FIRST_CHANNEL_DC_LEVEL,
    input  wire logic signed [12:0] SECOND_CHANNEL_DC_LEVEL,
    // tube drive
    output logic                    GRID1_N,
    output logic                    GRID2_N,
    output logic             [11:0] SEG
);

    // last count of the divider, hold timer and mute timer
    localparam logic [16:0] DIV_LAST  = 17'(OSC_DIV - 1);
    localparam logic [12:0] HOLD_LAST = 13'(HOLD_TICKS - 1);
    localparam logic [12:0] MUTE_LAST = 13'(MUTE_TICKS - 1);

    blmd_pkg::blmd_state_t st;
    blmd_pkg::blmd_state_t next_st;

    // per channel: selected level, bar height met, height on show
    logic signed [12:0] level [2];
    logic        [3:0]  count [2];
    logic        [3:0]  disp  [2];

    // scan tick and segment blanking
    logic               osc_tick;
    logic               blank;

    // bar height to thermometer pattern, point 1 in bit 0
    function automatic logic [11:0] therm(input logic [3:0] h);
        logic [11:0] b;
        b = 12'h000;
        for (int i = 0; i < `BLMD_POINTS; i++) begin
            b[i] = (4'(i) < h);
        end
        return b;
    endfunction

    // one step of a tick counter, wrapping inside its field
    function automatic logic [12:0] tick_inc(input logic [12:0] v);
        return 13'(v + 13'h0001);
    endfunction

    // true at the tick that moves the scan into the given slot
    function automatic logic enters_slot(input logic       tick,
                                         input logic [2:0] slot,
                                         input logic [2:0] target);
        return tick && (slot == target);
    endfunction

    // grid drive for a slot: low only while the scan sits in the grid's own slot
    function automatic logic grid_level(input logic [2:0] slot, input logic [2:0] own);
        return (slot != own);
    endfunction

    // height on show: held peak only when in the upper eight points and above now
    function automatic logic [3:0] shown_height(input logic [3:0] held,
                                                input logic [3:0] now);
        logic [3:0] h;
        h = now;
        if (held >= `BLMD_HOLD_LOW && held > now) begin
            h = held;
        end
        return h;
    endfunction

    // channel source select
    assign level[0] = AC_SELECT ? FIRST_CHANNEL_AC_LEVEL  : FIRST_CHANNEL_DC_LEVEL;
    assign level[1] = AC_SELECT ? SECOND_CHANNEL_AC_LEVEL : SECOND_CHANNEL_DC_LEVEL;

    // quantisers, one per channel
    // first channel
    blmd_quant u_quant0 (
        .level   (level[0]),
        .ac_mode (AC_SELECT),
        .count   (count[0])
    );

    // second channel
    blmd_quant u_quant1 (
        .level   (level[1]),
        .ac_mode (AC_SELECT),
        .count   (count[1])
    );

    // next state
    always_comb begin
        // hold everything by default
        next_st  = st;

        // oscillator divider: one tick every OSC_DIV clocks
        osc_tick = (st.div == DIV_LAST);
        next_st.div = osc_tick ? 17'h00000 : 17'(st.div + 17'h00001);

        // scan slot: one step per tick, eight slots to a frame
        if (osc_tick) begin
            next_st.slot = 3'(st.slot + 3'h1);
        end

        // power-on mute interval counted in oscillator ticks
        // phase leaves muting after MUTE_TICKS ticks, returns only on reset
        if (st.phase == blmd_pkg::BLMD_MUTING && osc_tick) begin
            if (st.mute_cnt == MUTE_LAST) begin
                next_st.phase = blmd_pkg::BLMD_RUN;
            end else begin
                next_st.mute_cnt = tick_inc(st.mute_cnt);
            end
        end

        // peak hold per channel
        // a higher height takes over the hold and restarts the timer
        // the timer counts ticks while the height stays at or below the hold
        // the mode is remembered to catch a switch between ac and dc
        next_st.ac_prev = AC_SELECT;
        for (int c = 0; c < 2; c++) begin
            if (!AC_SELECT || (st.ac_prev != AC_SELECT)) begin
                next_st.hold_lvl[c] = 4'h0;
                next_st.hold_cnt[c] = 13'h0000;
            end else if (count[c] > st.hold_lvl[c]) begin
                next_st.hold_lvl[c] = count[c];
                next_st.hold_cnt[c] = 13'h0000;
            end else if (osc_tick) begin
                if (st.hold_cnt[c] == HOLD_LAST) begin
                    next_st.hold_lvl[c] = count[c];
                    next_st.hold_cnt[c] = 13'h0000;
                end else begin
                    next_st.hold_cnt[c] = tick_inc(st.hold_cnt[c]);
                end
            end
            // held height shown only when it reaches the upper eight points
            disp[c] = shown_height(st.hold_lvl[c], count[c]);
        end

        // grids: one slot each out of eight, low while lit
        // taken from the next slot, so a grid changes on the tick edge itself
        // own slots lie four apart, so the grids never overlap
        next_st.grid1_n = grid_level(next_st.slot, `BLMD_SLOT_GRID1);
        next_st.grid2_n = grid_level(next_st.slot, `BLMD_SLOT_GRID2);

        // segments: loaded only in dark slots ahead of each grid
        // blanking wins over a load, so mute never lets a stale bar through
        // between loads the last pattern stands
        blank = MUTE || (st.phase != blmd_pkg::BLMD_RUN);
        if (blank) begin
            next_st.seg = 12'h000;
        end else if (enters_slot(osc_tick, next_st.slot, `BLMD_SLOT_LOAD1)) begin
            next_st.seg = therm(disp[0]);
        end else if (enters_slot(osc_tick, next_st.slot, `BLMD_SLOT_LOAD2)) begin
            next_st.seg = therm(disp[1]);
        end
    end

    // state register
    // reset: scan dark at slot 1, counters cleared, power-on mute armed
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st          <= '0;
            st.slot     <= `BLMD_SLOT_RST;
            st.phase    <= blmd_pkg::BLMD_MUTING;
            st.seg      <= `BLMD_SEG_RST;
            st.grid1_n  <= `BLMD_GRID_RST;
            st.grid2_n  <= `BLMD_GRID_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    // registered, so the tube pins never glitch between clock edges
    assign GRID1_N = st.grid1_n;
    assign GRID2_N = st.grid2_n;
    assign SEG     = st.seg;

endmodule

//--- rtl/blmd_defs.svh
// timing counts, thresholds and reset values of the bar level meter display
`ifndef BLMD_DEFS_SVH
`define BLMD_DEFS_SVH

// system clock and nominal on-chip oscillator rate
`define BLMD_CLK_HZ      100000000
`define BLMD_OSC_HZ      2000

// peak hold and power-on mute times, in milliseconds at the nominal oscillator
`define BLMD_HOLD_MS     2000
`define BLMD_MUTE_MS     1000

// multiplex frame: eight oscillator slots, one per grid
`define BLMD_SLOTS       8
`define BLMD_SLOT_GRID1  3'h0
`define BLMD_SLOT_GRID2  3'h4
`define BLMD_SLOT_LOAD1  3'h7
`define BLMD_SLOT_LOAD2  3'h3

// bar geometry
`define BLMD_POINTS      12
`define BLMD_HOLD_LOW    4'h5

// level input width and ac thresholds in dB, points 12 down to 1
`define BLMD_LVL_W       13
`define BLMD_AC_THR      '{13'sd10, 13'sd7, 13'sd4, 13'sd2, 13'sd0, -13'sd2, \
                           -13'sd4, -13'sd7, -13'sd10, -13'sd20, -13'sd30, -13'sd40}
// dc thresholds in millivolts, points 12 down to 1
`define BLMD_DC_THR      '{13'sd2490, 13'sd2130, 13'sd1800, 13'sd1630, 13'sd1460, \
                           13'sd1310, 13'sd1180, 13'sd980, 13'sd820, 13'sd440, \
                           13'sd220, 13'sd90}

// reset values
`define BLMD_SEG_RST     12'h000
`define BLMD_GRID_RST    1'h1
`define BLMD_SLOT_RST    3'h1

`endif

//--- rtl/blmd_pkg.sv
// types of the bar level meter display
package blmd_pkg;

    // power-on mute phase
    typedef enum logic {
        BLMD_MUTING,
        BLMD_RUN
    } blmd_phase_t;

    // whole state of the controller
    typedef struct packed {
        logic [16:0]       div;
        logic [2:0]        slot;
        blmd_phase_t       phase;
        logic [12:0]       mute_cnt;
        logic [1:0][3:0]   hold_lvl;
        logic [1:0][12:0]  hold_cnt;
        logic              ac_prev;
        logic [11:0]       seg;
        logic              grid1_n;
        logic              grid2_n;
    } blmd_state_t;

endpackage

//--- rtl/blmd_quant.sv
// level quantiser: counts thresholds met, giving a bar height of 0 to 12
`timescale 1ns/100ps
`include "blmd_defs.svh"

module blmd_quant (
    // level sample and mode
    input  wire logic signed [12:0] level,
    input  wire logic               ac_mode,
    // bar height
    output logic             [3:0]  count
);

    localparam logic signed [12:0] AC_THR [12] = `BLMD_AC_THR;
    localparam logic signed [12:0] DC_THR [12] = `BLMD_DC_THR;

    // count met thresholds; thresholds fall monotonically so the count is a bar height
    always_comb begin
        count = 4'h0;
        for (int i = 0; i < `BLMD_POINTS; i++) begin
            if (ac_mode ? (level >= AC_THR[i]) : (level >= DC_THR[i])) begin
                count = count + 4'h1;
            end
        end
    end

endmodule

//--- test/blmd_monitor.sv
// checker of grid scan, blanking and bar shape at the tube outputs
`timescale 1ns/100ps
module blmd_monitor #(
    parameter int OSC_DIV    = 4,
    parameter int MUTE_TICKS = 10
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // mute and tube drive
    input  wire logic        MUTE,
    input  wire logic        GRID1_N,
    input  wire logic        GRID2_N,
    input  wire logic [11:0] SEG
);
    localparam int HALF     = 4 * OSC_DIV;
    localparam int MUTE_CLK = MUTE_TICKS * OSC_DIV;
    logic [15:0] since;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    // clocks since reset release, saturating
    always_ff @(posedge REF_CLK) begin
        since <= RESET ? 16'h0000 : ((since == 16'hFFFF) ? since : since + 16'h0001);
    end
    chk_grid_excl: assert property (!GRID1_N |-> GRID2_N)
        else $error("both grids low together");
    chk_grid_width: assert property ($fell(GRID1_N) |-> ##OSC_DIV $rose(GRID1_N))
        else $error("grid one low time wrong");
    chk_grid_phase: assert property ($fell(GRID1_N) |-> ##HALF $fell(GRID2_N))
        else $error("grid two slot misplaced");
    chk_grid_alt: assert property ($fell(GRID2_N) |-> ##HALF $fell(GRID1_N))
        else $error("grid one slot misplaced");
    chk_mute_blank: assert property (MUTE |=> SEG == 12'h000)
        else $error("segments lit under mute");
    chk_bar_shape: assert property (((SEG + 12'h001) & SEG) == 12'h000)
        else $error("segments not a bar");
    chk_seg_dark: assert property ($changed(SEG) && !$past(MUTE) && !$past(MUTE, 2)
        |-> GRID1_N && GRID2_N) else $error("segments changed under a lit grid");
    chk_power_mute: assert property (since < MUTE_CLK |-> SEG == 12'h000)
        else $error("segments lit during power-on blanking");
endmodule

bind blmd_top blmd_monitor #(.OSC_DIV(OSC_DIV), .MUTE_TICKS(MUTE_TICKS)) blmd_monitor_inst (
    .REF_CLK(REF_CLK), .RESET(RESET), .MUTE(MUTE),
    .GRID1_N(GRID1_N), .GRID2_N(GRID2_N), .SEG(SEG));

//--- test/blmd_tube.sv
// tube model: keeps the pattern last lit under each grid
`timescale 1ns/100ps
module blmd_tube (
    // tube drive
    input  wire logic        clk,
    input  wire logic        grid1_n,
    input  wire logic        grid2_n,
    input  wire logic [11:0] seg,
    // pattern last lit per grid
    output logic      [11:0] shown1,
    output logic      [11:0] shown2
);
    // a section glows only while its grid is low
    always_ff @(posedge clk) begin
        if (!grid1_n) shown1 <= seg;
        if (!grid2_n) shown2 <= seg;
    end
endmodule

//--- test/blmd_top_tb.sv
// self-checking bench of the bar level meter display
`timescale 1ns/100ps
module blmd_top_tb;
    logic               clk  = 1'b0;
    logic               rst  = 1'b1;
    logic               ac   = 1'b0;
    logic               mute = 1'b0;
    logic signed [12:0] a1 = 13'h0000, a2 = 13'h0000, d1 = 13'h0000, d2 = 13'h0000;
    logic               grid1_n, grid2_n;
    logic        [11:0] seg, shown1, shown2;
    int                 num_errors = 0;
    int                 total_checks = 0;
    int ac_thr[12] = '{-40, -30, -20, -10, -7, -4, -2, 0, 2, 4, 7, 10};
    int dc_thr[12] = '{90, 220, 440, 820, 980, 1180, 1310, 1460, 1630, 1800, 2130, 2490};

    // clock
    always #5 clk = ~clk;

    blmd_top #(.OSC_DIV(4), .HOLD_TICKS(64), .MUTE_TICKS(10)) blmd_top_inst (
        .REF_CLK(clk), .RESET(rst), .AC_SELECT(ac), .MUTE(mute),
        .FIRST_CHANNEL_AC_LEVEL(a1), .SECOND_CHANNEL_AC_LEVEL(a2),
        .FIRST_CHANNEL_DC_LEVEL(d1), .SECOND_CHANNEL_DC_LEVEL(d2),
        .GRID1_N(grid1_n), .GRID2_N(grid2_n), .SEG(seg));
    blmd_tube blmd_tube_inst (.clk(clk), .grid1_n(grid1_n), .grid2_n(grid2_n), .seg(seg),
        .shown1(shown1), .shown2(shown2));

    function automatic logic [11:0] bar(input int h);
        return (12'h001 << h) - 12'h001;
    endfunction
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // unselected inputs get the opposite extreme so a wrong pick shows
    task automatic drive(input logic m, input int l1, input int l2);
        @(posedge clk);
        ac <= m;
        a1 <= 13'(m ? l1 : 100);
        a2 <= 13'(m ? l2 : 100);
        d1 <= 13'(m ? 0 : l1);
        d2 <= 13'(m ? 0 : l2);
    endtask
    task automatic frames(input int n);
        repeat (n * 32) @(posedge clk);
        #1;
    endtask
    task automatic t_reset_mute;
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        drive(1'b1, 100, 100);
        repeat (30) @(posedge clk);
        #1;
        check(seg, 12'h000);
        check(shown1, 12'h000);
        check(shown2, 12'h000);
        frames(3);
        check(shown1, bar(12));
    endtask
    // ac climbs so no hold shows; dc falls and must not hold
    task automatic t_bars(input logic m, input int thr[12]);
        int i;
        drive(!m, 0, 0);
        frames(1);
        for (int k = 0; k < 12; k++) begin
            i = m ? k : 11 - k;
            drive(m, thr[i], thr[i] - 1);
            frames(2);
            check(shown1, bar(i + 1));
            check(shown2, bar(i));
        end
    endtask
    task automatic t_peak;
        drive(1'b0, 0, 0);
        frames(1);
        drive(1'b1, -40, -40);
        frames(2);
        drive(1'b1, 10, -10);
        repeat (40) @(posedge clk);
        #1;
        check(shown1, bar(12));
        drive(1'b1, -40, -40);
        frames(2);
        check(shown1, bar(12));
        check(shown2, bar(1));
        frames(4);
        check(shown1, bar(12));
        frames(4);
        check(shown1, bar(1));
    endtask
    task automatic t_mute;
        drive(1'b1, 100, 100);
        mute <= 1'b1;
        frames(2);
        check(shown1, 12'h000);
        check(shown2, 12'h000);
        @(posedge clk);
        mute <= 1'b0;
        frames(2);
        check(shown2, bar(12));
        check(shown1, bar(12));
    endtask
    task automatic conclude;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        t_reset_mute();
        t_bars(1'b1, ac_thr);
        t_peak();
        t_bars(1'b0, dc_thr);
        t_mute();
        t_reset_mute();
        conclude();
    end
    // watchdog
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
